//--- src/mdsu_pkg.sv
// Package: operation codes, widths and reset values for the multiply/divide/clamp unit
package mdsu_pkg;

    // Operations issued by decode
    typedef enum logic [3:0] {
        MDSU_OP_NONE,
        MDSU_OP_PRODUCT_LOW_WORD,
        MDSU_OP_PRODUCT_ACCUMULATE,
        MDSU_OP_PRODUCT_SUBTRACT,
        MDSU_OP_UNSIGNED_LONG_PRODUCT,
        MDSU_OP_UNSIGNED_LONG_PRODUCT_ACC,
        MDSU_OP_SIGNED_LONG_PRODUCT,
        MDSU_OP_SIGNED_LONG_PRODUCT_ACC,
        MDSU_OP_SIGNED_QUOTIENT,
        MDSU_OP_UNSIGNED_QUOTIENT,
        MDSU_OP_SIGNED_CLAMP,
        MDSU_OP_UNSIGNED_CLAMP
    } mdsu_op_t;

    localparam int MDSU_WORD_W = 32;
    localparam int MDSU_DIV_CYCLES = 32;
    localparam logic [31:0] MDSU_WORD_RST = 32'h0000_0000;
    localparam logic [5:0] MDSU_COUNT_RST = 6'h00;
    localparam logic [5:0] MDSU_DIV_LAST = 6'h1F;
    localparam logic MDSU_FLAG_RST = 1'b0;

endpackage : mdsu_pkg

//--- src/mdsu_divider.sv
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module mdsu_divider
    import mdsu_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic start, // Begin a division, one-cycle pulse
    input wire logic is_signed, // Two's complement operands
    input wire logic [31:0] dividend, // Value to be divided
    input wire logic [31:0] divisor, // Divisor
    output logic busy, // Division in progress
    output logic done, // Quotient valid, one-cycle pulse
    output logic [31:0] quotient // Quotient, held until next done
);

    typedef struct packed {
        logic busy;
        logic done;
        logic negate;
        logic zero_div;
        logic [5:0] count;
        logic [31:0] rem;
        logic [31:0] quo;
        logic [31:0] dsr;
        logic [31:0] result;
    } mdsu_div_state_t;

    mdsu_div_state_t state_reg;
    mdsu_div_state_t state_next;

    logic [32:0] trial;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Magnitudes are divided, sign fixed at the end; that truncates toward zero
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        trial = {state_reg.rem, state_reg.quo[31]} - {1'b0, state_reg.dsr};
        if (start && !state_reg.busy) begin
            state_next.busy = 1'b1;
            state_next.count = MDSU_COUNT_RST;
            state_next.rem = MDSU_WORD_RST;
            state_next.zero_div = (divisor == MDSU_WORD_RST);
            state_next.negate = is_signed && (dividend[31] ^ divisor[31]);
            state_next.quo = (is_signed && dividend[31]) ? 32'(-dividend) : dividend;
            state_next.dsr = (is_signed && divisor[31]) ? 32'(-divisor) : divisor;
        end else if (state_reg.busy) begin
            // Shift-subtract step
            if (!trial[32]) begin
                state_next.rem = trial[31:0];
                state_next.quo = {state_reg.quo[30:0], 1'b1};
            end else begin
                state_next.rem = {state_reg.rem[30:0], state_reg.quo[31]};
                state_next.quo = {state_reg.quo[30:0], 1'b0};
            end
            state_next.count = 6'(state_reg.count + 6'h01);
            if (state_reg.count == MDSU_DIV_LAST) begin
                state_next.busy = 1'b0;
                state_next.done = 1'b1;
                if (state_reg.zero_div) begin
                    state_next.result = MDSU_WORD_RST;
                end else if (state_reg.negate) begin
                    state_next.result = 32'(-state_next.quo);
                end else begin
                    state_next.result = state_next.quo;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign busy = state_reg.busy;
    assign done = state_reg.done;
    assign quotient = state_reg.result;

endmodule : mdsu_divider
`default_nettype wire

//--- src/mdsu_unit.sv
// Multiply, long multiply, divide and clamp execution unit
//
// Fast paths finish in one cycle; the divider stalls issue meanwhile.
`timescale 1ns/1ps
`default_nettype none
module mdsu_unit
    import mdsu_pkg::*;
(
    input wire logic clk, // Core clock, 25 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic issue_valid, // Operation offered this cycle
    input wire mdsu_op_t issue_op, // Operation code
    input wire logic set_flags, // Flag-setting form of low-word product
    input wire logic [31:0] first_operand_reg, // First source operand value
    input wire logic [31:0] second_operand_reg, // Second source operand value
    input wire logic [31:0] addend_reg, // Addend / minuend value
    input wire logic [31:0] dest_upper_in, // Upper word of accumulator pair
    input wire logic [31:0] dest_lower_in, // Lower word of accumulator pair
    input wire logic [5:0] clamp_width, // Target width n
    input wire logic shift_right, // Pre-shift is arithmetic right
    input wire logic [4:0] shift_amount, // Pre-shift amount
    input wire logic status_write_op, // Status write of sticky flag
    input wire logic status_write_value, // Value written to sticky flag
    input wire logic flag_n_in, // Current negative flag
    input wire logic flag_z_in, // Current zero flag
    input wire logic flag_c_in, // Current carry flag
    input wire logic flag_v_in, // Current overflow flag
    output logic issue_ready, // Operation can be taken
    output logic result_valid, // Result valid, one-cycle pulse
    output logic result_long, // Result has an upper word
    output logic [31:0] dest_lower_word, // Lower / only result word
    output logic [31:0] dest_upper_word, // Upper result word
    output logic flags_write, // Flag outputs are to be written
    output logic flag_n_out, // Negative flag result
    output logic flag_z_out, // Zero flag result
    output logic flag_c_out, // Carry flag result
    output logic flag_v_out, // Overflow flag result
    output logic sat_flag // Sticky saturation flag, status read
);

    typedef struct packed {
        logic valid;
        logic is_long;
        logic flags_wr;
        logic [31:0] lower;
        logic [31:0] upper;
        logic fn;
        logic fz;
        logic fc;
        logic fv;
        logic sticky;
    } mdsu_state_t;

    mdsu_state_t state_reg;
    mdsu_state_t state_next;

    // Issue handshake and divider interface
    logic take;
    logic div_start;
    logic div_start_d;
    logic div_signed;
    logic div_busy;
    logic div_done;
    logic [31:0] div_quotient;

    // Datapaths
    logic [63:0] prod_unsigned;
    logic signed [63:0] prod_signed;
    logic [63:0] long_acc;

    // Clamp path
    logic [31:0] shifted;
    logic [31:0] clamped;
    logic saturated;

    // ----------------------------------------------------------------
    // Divider, multi-cycle
    // ----------------------------------------------------------------
    // Taken on any edge that sees offer and ready
    assign take = issue_valid && issue_ready;
    assign div_signed = (issue_op == MDSU_OP_SIGNED_QUOTIENT);
    assign div_start = take && (div_signed || issue_op == MDSU_OP_UNSIGNED_QUOTIENT);

    // Stalling issue while dividing keeps one result in flight at a time;
    // the done cycle is refused too, else a take there would drop the quotient
    assign issue_ready = !div_busy && !div_start_d && !div_done;

    // Guard for the cycle right after a start
    always_ff @(posedge clk) begin
        if (rst) begin
            div_start_d <= MDSU_FLAG_RST;
        end else begin
            div_start_d <= div_start;
        end
    end

    // Operands are read on the start cycle only
    mdsu_divider u_divider (
        .clk(clk),
        .rst(rst),
        .start(div_start),
        .is_signed(div_signed),
        .dividend(first_operand_reg),
        .divisor(second_operand_reg),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_quotient)
    );

    // ----------------------------------------------------------------
    // Multipliers
    // ----------------------------------------------------------------
    // Low 32 bits are the same for signed and unsigned, so unsigned serves both
    assign prod_unsigned = {32'h0000_0000, first_operand_reg} *
                           {32'h0000_0000, second_operand_reg};
    // Sign-extended operands give the true signed product
    assign prod_signed = $signed({{32{first_operand_reg[31]}}, first_operand_reg}) *
                         $signed({{32{second_operand_reg[31]}}, second_operand_reg});

    // Destination pair as one accumulator, upper word on top
    assign long_acc = {dest_upper_in, dest_lower_in};

    // ----------------------------------------------------------------
    // Clamp: pre-shift, then compare against n-bit range
    // ----------------------------------------------------------------
    // A right shift of zero places passes the value through
    assign shifted = shift_right ? 32'($signed(first_operand_reg) >>> shift_amount)
                                 : 32'(first_operand_reg << shift_amount);

    // Limits are 33 bits so signed n = 32 and the input sign both fit
    always_comb begin
        logic signed [32:0] hi_lim;
        logic signed [32:0] lo_lim;
        logic signed [32:0] val;
        hi_lim = '0;
        lo_lim = '0;
        val = 33'($signed(shifted));
        if (issue_op == MDSU_OP_SIGNED_CLAMP) begin
            // Width 0 is not legal here; treated as 1 to stay defined
            if (clamp_width <= 6'd1) begin
                hi_lim = 33'sd0;
                lo_lim = -33'sd1;
            end else begin
                hi_lim = 33'((33'sd1 <<< (clamp_width - 6'd1)) - 33'sd1);
                lo_lim = 33'(-(33'sd1 <<< (clamp_width - 6'd1)));
            end
        end else begin
            // Only n[4:0] is used, so widths of 32 or more wrap
            hi_lim = 33'((33'sd1 <<< clamp_width[4:0]) - 33'sd1);
            lo_lim = 33'sd0;
        end

        if (val > hi_lim) begin
            clamped = hi_lim[31:0];
        end else if (val < lo_lim) begin
            clamped = lo_lim[31:0];
        end else begin
            clamped = shifted;
        end

        // Any change from the shifted input is saturation
        saturated = (clamped != shifted);
    end

    // ----------------------------------------------------------------
    // Result and flag next-state
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.valid = 1'b0;
        state_next.flags_wr = 1'b0;
        // Flags pass through unchanged unless an operation updates them
        // C and V are never written by this unit
        state_next.fn = flag_n_in;
        state_next.fz = flag_z_in;
        state_next.fc = flag_c_in;
        state_next.fv = flag_v_in;

        if (take) begin
            // A divide shows nothing until its quotient is ready
            state_next.valid = !div_start;
            state_next.is_long = 1'b0;
            // 32-bit results clear the upper word
            state_next.upper = MDSU_WORD_RST;
            case (issue_op)
                MDSU_OP_PRODUCT_LOW_WORD: begin
                    state_next.lower = prod_unsigned[31:0];
                    // Flag form changes N and Z only
                    if (set_flags) begin
                        state_next.flags_wr = 1'b1;
                        state_next.fn = prod_unsigned[31];
                        state_next.fz = (prod_unsigned[31:0] == MDSU_WORD_RST);
                    end
                end

                MDSU_OP_PRODUCT_ACCUMULATE: begin
                    state_next.lower = 32'(prod_unsigned[31:0] + addend_reg);
                end
                MDSU_OP_PRODUCT_SUBTRACT: begin
                    state_next.lower = 32'(addend_reg - prod_unsigned[31:0]);
                end

                MDSU_OP_UNSIGNED_LONG_PRODUCT: begin
                    state_next.is_long = 1'b1;
                    {state_next.upper, state_next.lower} = prod_unsigned;
                end
                MDSU_OP_UNSIGNED_LONG_PRODUCT_ACC: begin
                    // Carry out of bit 63 is dropped
                    state_next.is_long = 1'b1;
                    {state_next.upper, state_next.lower} =
                        64'(prod_unsigned + long_acc);
                end
                MDSU_OP_SIGNED_LONG_PRODUCT: begin
                    state_next.is_long = 1'b1;
                    {state_next.upper, state_next.lower} = prod_signed;
                end
                MDSU_OP_SIGNED_LONG_PRODUCT_ACC: begin
                    // Signed sum wraps modulo two to the 64
                    state_next.is_long = 1'b1;
                    {state_next.upper, state_next.lower} =
                        64'(prod_signed + $signed(long_acc));
                end

                MDSU_OP_SIGNED_CLAMP, MDSU_OP_UNSIGNED_CLAMP: begin
                    // Sticky flag is handled below, after any status write
                    state_next.lower = clamped;
                end

                default: begin
                    // Unknown codes repeat the previous word
                    state_next.lower = state_reg.lower;
                end
            endcase
        end else if (div_done) begin
            // Issue is refused in this cycle, so no take can collide
            state_next.valid = 1'b1;
            state_next.is_long = 1'b0;
            state_next.upper = MDSU_WORD_RST;
            state_next.lower = div_quotient;
        end

        // Sticky flag: a status write clears or sets it, saturation wins over a clear
        if (status_write_op) begin
            state_next.sticky = status_write_value;
        end
        if (take && saturated &&
            (issue_op == MDSU_OP_SIGNED_CLAMP || issue_op == MDSU_OP_UNSIGNED_CLAMP)) begin
            state_next.sticky = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Synchronous reset clears results and the sticky flag
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output but issue_ready is a flip-flop of the state struct; issue_ready is combinational from the divider and div_start_d
    assign result_valid = state_reg.valid;
    assign result_long = state_reg.is_long;
    assign dest_lower_word = state_reg.lower;
    assign dest_upper_word = state_reg.upper;
    assign flags_write = state_reg.flags_wr;
    assign flag_n_out = state_reg.fn;
    assign flag_z_out = state_reg.fz;
    assign flag_c_out = state_reg.fc;
    assign flag_v_out = state_reg.fv;
    assign sat_flag = state_reg.sticky;

endmodule : mdsu_unit
`default_nettype wire

//--- testbench/mdsu_unit_asserts.sv
// Concurrent checks on the ports of the multiply, divide and clamp unit
`timescale 1ns/1ps
`default_nettype none
module mdsu_unit_asserts
    import mdsu_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset
    input wire logic issue_valid, // Offer
    input wire mdsu_op_t issue_op, // Operation
    input wire logic set_flags, // Flag form
    input wire logic [31:0] first_operand_reg, // First operand
    input wire logic [31:0] second_operand_reg, // Second operand
    input wire logic status_write_op, // Status write
    input wire logic flag_n_in, // Negative in
    input wire logic flag_z_in, // Zero in
    input wire logic flag_c_in, // Carry in
    input wire logic flag_v_in, // Overflow in
    input wire logic issue_ready, // Taken when offered
    input wire logic result_valid, // Answer pulse
    input wire logic [31:0] dest_lower_word, // Lower word
    input wire logic [31:0] dest_upper_word, // Upper word
    input wire logic flags_write, // Flag write pulse
    input wire logic flag_n_out, // Negative out
    input wire logic flag_z_out, // Zero out
    input wire logic flag_c_out, // Carry out
    input wire logic flag_v_out, // Overflow out
    input wire logic sat_flag // Sticky saturation
);
    // ---------------------------------
    // Properties
    // ---------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire take = issue_valid && issue_ready;
    // Divide takes many cycles, so its answer is tied to the taking edge
    sequence s_div_take;
        take && issue_op inside {MDSU_OP_SIGNED_QUOTIENT, MDSU_OP_UNSIGNED_QUOTIENT};
    endsequence
    property p_low;
        logic [31:0] v;
        (take && issue_op == MDSU_OP_PRODUCT_LOW_WORD, v = first_operand_reg * second_operand_reg)
            |=> result_valid && dest_lower_word == v;
    endproperty
    property p_long(mdsu_op_t o, bit sgn);
        logic [63:0] v;
        (take && issue_op == o, v = sgn ? 64'($signed(first_operand_reg)) * 64'($signed(
            second_operand_reg)) : {32'h0000_0000, first_operand_reg} * second_operand_reg)
            |=> {dest_upper_word, dest_lower_word} == v;
    endproperty
    a_low_word: assert property (p_low) else $error("low word product wrong");
    a_unsigned_long: assert property (p_long(MDSU_OP_UNSIGNED_LONG_PRODUCT, 0))
        else $error("unsigned long product wrong");
    a_signed_long: assert property (p_long(MDSU_OP_SIGNED_LONG_PRODUCT, 1))
        else $error("signed long product wrong");
    a_flag_form: assert property (
        take && issue_op == MDSU_OP_PRODUCT_LOW_WORD && set_flags |=> flags_write
        && flag_n_out == dest_lower_word[31] && flag_z_out == (dest_lower_word == 0)
        && flag_c_out == $past(flag_c_in) && flag_v_out == $past(flag_v_in))
        else $error("flag form wrong");
    a_long_flags: assert property (
        take && issue_op inside {[MDSU_OP_UNSIGNED_LONG_PRODUCT:MDSU_OP_SIGNED_LONG_PRODUCT_ACC]}
        |=> !flags_write && {flag_n_out, flag_z_out, flag_c_out, flag_v_out}
        == {$past(flag_n_in), $past(flag_z_in), $past(flag_c_in), $past(flag_v_in)})
        else $error("long product touched flags");
    a_div_answer: assert property (s_div_take |-> ##34 result_valid && !flags_write)
        else $error("divide answer late or flags written");
    a_div_busy: assert property (s_div_take |=> !issue_ready [*8])
        else $error("divide accepted a second operation");
    a_done_refused: assert property (s_div_take |-> ##33 !issue_ready)
        else $error("operation taken while quotient pending");
    a_div_zero: assert property (
        s_div_take ##0 second_operand_reg == 0 |-> ##34 dest_lower_word == 32'h0000_0000)
        else $error("divide by zero not zero");
    a_sticky_clear: assert property ($fell(sat_flag) |-> $past(status_write_op))
        else $error("sticky flag cleared without write");
endmodule : mdsu_unit_asserts

bind mdsu_unit mdsu_unit_asserts u_chk (.clk, .rst, .issue_valid, .issue_op, .set_flags,
    .first_operand_reg, .second_operand_reg, .status_write_op, .flag_n_in, .flag_z_in,
    .flag_c_in, .flag_v_in, .issue_ready, .result_valid, .dest_lower_word, .dest_upper_word,
    .flags_write, .flag_n_out, .flag_z_out, .flag_c_out, .flag_v_out, .sat_flag);
`default_nettype wire

//--- testbench/mdsu_issuer.sv
// Decode-side model: offers operations and keeps the accumulator register pair
`timescale 1ns/1ps
`default_nettype none
module mdsu_issuer
    import mdsu_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic req, // One-cycle request from the bench
    input wire logic issue_ready, // Unit can take an offer
    input wire logic result_valid, // Answer pulse
    input wire logic result_long, // Answer has an upper word
    input wire logic [31:0] dest_upper_word, // Upper answer word
    input wire logic [31:0] dest_lower_word, // Lower answer word
    output logic issue_valid, // Offer to the unit
    output logic [31:0] dest_upper_in, // Upper register of the pair
    output logic [31:0] dest_lower_in // Lower register of the pair
);
    initial begin
        issue_valid = 1'h0;
        dest_upper_in = 32'h0123_4567;
        dest_lower_in = 32'h89AB_CDEF;
    end
    // Offer stands until an edge sees ready; a refused offer is not queued
    always @(posedge clk) begin
        if (issue_valid && issue_ready) begin
            issue_valid <= 1'h0;
        end else if (req) begin
            issue_valid <= 1'h1;
        end
    end
    // Only general registers exist here; long answers go to two distinct ones
    always @(posedge clk) begin
        if (result_valid && result_long) begin
            dest_upper_in <= dest_upper_word;
            dest_lower_in <= dest_lower_word;
        end
    end
endmodule : mdsu_issuer
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the multiply, divide and clamp unit
`timescale 1ns/1ps
`default_nettype none
module tb
    import mdsu_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic req = 1'h0;
    logic set_flags = 1'h0, shift_right = 1'h0, status_write_op = 1'h0;
    logic status_write_value = 1'h0, exp_sat = 1'h0;
    logic flag_n_in = 1'h0, flag_z_in = 1'h0, flag_c_in = 1'h0, flag_v_in = 1'h0;
    logic [31:0] first_operand_reg = '0, second_operand_reg = '0, addend_reg = '0;
    mdsu_op_t issue_op = MDSU_OP_NONE;
    logic [5:0] clamp_width = 6'h00;
    logic [4:0] shift_amount = 5'h00;
    wire logic issue_valid, issue_ready, result_valid, result_long, flags_write, sat_flag;
    wire logic flag_n_out, flag_z_out, flag_c_out, flag_v_out;
    wire logic [31:0] dest_lower_word, dest_upper_word, dest_upper_in, dest_lower_in;
    int fail_count = 0;
    int samples_checked = 0;

    mdsu_unit dut (.clk, .rst, .issue_valid, .issue_op, .set_flags, .first_operand_reg,
        .second_operand_reg, .addend_reg, .dest_upper_in, .dest_lower_in, .clamp_width,
        .shift_right, .shift_amount, .status_write_op, .status_write_value, .flag_n_in,
        .flag_z_in, .flag_c_in, .flag_v_in, .issue_ready, .result_valid, .result_long,
        .dest_lower_word, .dest_upper_word, .flags_write, .flag_n_out, .flag_z_out,
        .flag_c_out, .flag_v_out, .sat_flag);
    mdsu_issuer u_issuer (.clk, .req, .issue_ready, .result_valid, .result_long,
        .dest_upper_word, .dest_lower_word, .issue_valid, .dest_upper_in, .dest_lower_in);

    always #20 clk = ~clk;

    // ---------------------------------
    // Expectations and checking
    // ---------------------------------
    function automatic logic [63:0] model(input mdsu_op_t op, input logic [31:0] a, b, c, h, l);
        logic [63:0] u;
        logic [63:0] s;
        u = {32'h0000_0000, a} * b;
        s = 64'($signed(a)) * 64'($signed(b));
        case (op)
            MDSU_OP_PRODUCT_LOW_WORD: return u[31:0];
            MDSU_OP_PRODUCT_ACCUMULATE: return 32'(u[31:0] + c);
            MDSU_OP_PRODUCT_SUBTRACT: return 32'(c - u[31:0]);
            MDSU_OP_UNSIGNED_LONG_PRODUCT: return u;
            MDSU_OP_UNSIGNED_LONG_PRODUCT_ACC: return u + {h, l};
            MDSU_OP_SIGNED_LONG_PRODUCT: return s;
            MDSU_OP_SIGNED_LONG_PRODUCT_ACC: return s + {h, l};
            MDSU_OP_SIGNED_QUOTIENT: return (b == 0) ? '0 : 32'($signed(a) / $signed(b));
            MDSU_OP_UNSIGNED_QUOTIENT: return (b == 0) ? '0 : a / b;
            default: return '0;
        endcase
    endfunction : model

    // Result {saturated, value}; bounds kept in 64 bits so width 32 cannot wrap
    function automatic logic [32:0] clampx(input logic [31:0] a, input int n, bit u, r, int s);
        longint v, hi, lo;
        logic [31:0] x;
        x = r ? 32'($signed(a) >>> s) : a << s;
        v = longint'($signed(x));
        hi = u ? (longint'(1) << n) - 1 : (longint'(1) << (n - 1)) - 1;
        lo = u ? 0 : -(longint'(1) << (n - 1));
        if (v > hi) return {1'h1, 32'(hi)};
        if (v < lo) return {1'h1, 32'(lo)};
        return {1'h0, x};
    endfunction : clampx

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One operation through the issuer; clamp fields and flags drawn at random
    task automatic run(input mdsu_op_t op, input logic [31:0] a, b, c, input logic sf);
        logic [63:0] exp;
        logic [32:0] cl;
        logic [3:0] fl;
        int n, w, s;
        bit r;
        bit long_op;
        r = 1'($urandom);
        s = r ? 1 + $urandom % 31 : $urandom % 32;
        w = (op == MDSU_OP_SIGNED_CLAMP) ? 1 + $urandom % 32 : $urandom % 32;
        fl = 4'($urandom);
        @(posedge clk);
        issue_op <= op;
        first_operand_reg <= a;
        second_operand_reg <= b;
        addend_reg <= c;
        set_flags <= sf;
        shift_right <= r;
        shift_amount <= 5'(s);
        clamp_width <= 6'(w);
        {flag_n_in, flag_z_in, flag_c_in, flag_v_in} <= fl;
        req <= 1'h1;
        @(posedge clk);
        req <= 1'h0;
        @(negedge clk);
        exp = model(op, a, b, c, dest_upper_in, dest_lower_in);
        cl = clampx(a, w, op == MDSU_OP_UNSIGNED_CLAMP, r, s);
        if (op inside {MDSU_OP_SIGNED_CLAMP, MDSU_OP_UNSIGNED_CLAMP}) begin
            exp = cl[31:0];
            exp_sat = exp_sat | cl[32];
        end
        n = 0;
        while (result_valid !== 1'h1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (sf) fl[3:2] = {exp[31], exp[31:0] == 32'h0000_0000};
        check({dest_upper_word, dest_lower_word}, exp);
        check({flags_write, flag_n_out, flag_z_out, flag_c_out, flag_v_out}, {sf, fl});
        check(sat_flag, exp_sat);
        long_op = op inside {[MDSU_OP_UNSIGNED_LONG_PRODUCT:MDSU_OP_SIGNED_LONG_PRODUCT_ACC]};
        check({result_valid, result_long}, {1'h1, long_op});
    endtask : run

    task automatic burst(input int k);
        mdsu_op_t op;
        repeat (k) begin
            op = mdsu_op_t'(1 + $urandom % 11);
            run(op, $urandom, $urandom, $urandom, op == MDSU_OP_PRODUCT_LOW_WORD && 1'($urandom));
        end
    endtask : burst

    task automatic wr_sticky(input logic v);
        @(posedge clk);
        status_write_op <= 1'h1;
        status_write_value <= v;
        exp_sat = v;
        @(posedge clk);
        status_write_op <= 1'h0;
        @(negedge clk);
        check(sat_flag, v);
    endtask : wr_sticky

    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    // ---------------------------------
    // Main sequence and watchdog
    // ---------------------------------
    initial begin
        void'($urandom(32'hb90f));
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        for (int i = 1; i < 12; i++) run(mdsu_op_t'(i), '1, 32'h8000_0000, 32'h7FFF_FFFF, 1'h0);
        $display("test extremes done");
        run(MDSU_OP_PRODUCT_LOW_WORD, '0, 32'h1234_5678, '0, 1'h1);
        run(MDSU_OP_SIGNED_QUOTIENT, 32'hFFFF_FFF9, 32'h0000_0002, '0, 1'h0);
        run(MDSU_OP_SIGNED_QUOTIENT, 32'h0000_0007, '0, '0, 1'h0);
        run(MDSU_OP_UNSIGNED_QUOTIENT, 32'h0000_0007, '0, '0, 1'h0);
        $display("test corners done");
        burst(300);
        $display("test random done");
        wr_sticky(1'h0);
        wr_sticky(1'h1);
        wr_sticky(1'h0);
        burst(40);
        $display("test sticky done");
        summarize();
    end

    // Well above the few thousand cycles the tests need
    initial begin
        #(40 * 20000);
        fail_count++;
        summarize();
    end
endmodule : tb
`default_nettype wire
